// ==== inc/pwp_regs.vh ====
`ifndef PWP_REGS_VH
`define PWP_REGS_VH

// Register offsets, byte addresses on the word-wide bus.
`define PWP_CLR_OFFSET      12'h000
`define PWP_SET_OFFSET      12'h004

// Field positions inside the protection word.
`define PWP_EVENT_BIT       1
`define PWP_SERIAL_LSB      2
`define PWP_SERIAL_MSB      7
`define PWP_TIMER_LSB       8
`define PWP_TIMER_MSB       15
`define PWP_ADC_BIT         16
`define PWP_AC_BIT          17
`define PWP_DAC_BIT         18
`define PWP_TOUCH_BIT       19

// Bits that hold a real protection flag.
`define PWP_VALID_MASK      32'h000FFFFE
// Bits that read as a fixed one and ignore writes.
`define PWP_FIXED_ONES      32'h00800000
// Reset value of the protection flags.
`define PWP_FLAGS_RESET     32'h00000000

`endif

// ==== hdl/pwp_protect_clear.v ====
// Behaviour
// - Writing a zero to a protection bit of the clear register leaves that flag unchanged.
// - Writing a one to a protection bit of the clear register clears that peripheral's flag.
// - Reading a protection bit gives 1 while the peripheral is protected and 0 otherwise.
// - Bits 8 to 15 hold the protection of timer units zero to seven in ascending order.
// - Bits 2 to 7 hold the protection of serial units zero to five in ascending order.
`timescale 1ns/1ns
`default_nettype none
`include "pwp_regs.vh"

module pwp_protect_clear #(
  parameter ADDR_W = 12
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // AHB-Lite slave port.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // Protection state towards the guarded peripherals.
  output wire        event_router_protect_bit,
  output wire [5:0]  serial_unit_protect_bits,
  output wire [7:0]  timer_protect_bits,
  output wire [2:0]  analog_protect_bits,
  output wire        touch_unit_protect_bit
);

  // Register selector codes, one-hot.
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_CLR  = 2'b01;
  localparam [1:0] SEL_SET  = 2'b10;

  reg  [1:0]  rst_sync_r;
  wire        rst_int_n;
  reg  [31:0] prot_r;
  wire [31:0] prot_nxt;
  reg  [1:0]  wsel_r;
  reg  [31:0] rdata_nxt;
  wire        addr_phase;
  wire [1:0]  asel;

  // Decodes a byte address to a register selector.
  function [1:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == `PWP_CLR_OFFSET)
        reg_sel = SEL_CLR;
      else if (addr == `PWP_SET_OFFSET)
        reg_sel = SEL_SET;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // Reset is released through two flip-flops.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_int_n = rst_sync_r[1];

  // A transfer is taken when selected, active and the bus is ready.
  assign addr_phase = hsel && htrans[1] && hready;
  assign asel       = reg_sel(haddr[ADDR_W-1:0]);

  // One flag cell per bit position, built from the mask of assigned bits.
  // Unassigned positions are tied low so no write can ever reach them.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_flag
      if (((`PWP_VALID_MASK >> gi) & 32'h00000001) != 32'h00000000)
      begin : g_used
        // A one in a clear write drops the flag, a zero keeps it.
        assign prot_nxt[gi] = (wsel_r == SEL_CLR) ? (prot_r[gi] & ~hwdata[gi]) :
                              (wsel_r == SEL_SET) ? (prot_r[gi] | hwdata[gi]) :
                              prot_r[gi];
      end
      else
      begin : g_spare
        // Spare positions hold no state and ignore every write.
        assign prot_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // Read value taken from the updated flags so back-to-back access is coherent.
  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (asel != SEL_NONE)
      rdata_nxt = (prot_nxt & `PWP_VALID_MASK) | `PWP_FIXED_ONES;
  end

  // Protection flags, write capture and registered bus answers.
  always @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      prot_r    <= `PWP_FLAGS_RESET;
      wsel_r    <= SEL_NONE;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      prot_r    <= prot_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase && hwrite)
        wsel_r <= asel;
      else
        wsel_r <= SEL_NONE;
      if (addr_phase && !hwrite)
        hrdata <= rdata_nxt;
    end
  end

  // Per-peripheral flags straight from the flag register.
  assign event_router_protect_bit = prot_r[`PWP_EVENT_BIT];
  assign serial_unit_protect_bits = prot_r[`PWP_SERIAL_MSB:`PWP_SERIAL_LSB];
  assign timer_protect_bits       = prot_r[`PWP_TIMER_MSB:`PWP_TIMER_LSB];
  assign analog_protect_bits      = prot_r[`PWP_DAC_BIT:`PWP_ADC_BIT];
  assign touch_unit_protect_bit   = prot_r[`PWP_TOUCH_BIT];

endmodule

`default_nettype wire

// ==== sim/pwp_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwp_checker (
  // Bus side.
  input wire logic        clk, rst_n, hsel, hwrite, hready,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // Flag outputs.
  input wire logic [7:0]  timer_protect_bits,
  input wire logic [5:0]  serial_unit_protect_bits
);
  logic       wc_r, rd_r;
  wire [13:0] f = {timer_protect_bits, serial_unit_protect_bits};
  wire        go = hsel && htrans[1] && hready && haddr[11:0] == 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Marks the data phase of a write or a read of the clear register at offset 12'h000.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) {wc_r, rd_r} <= 2'h0;
    else {wc_r, rd_r} <= {go && hwrite, go && !hwrite};
  zero_keeps_a: assert property (wc_r |=> ((f ^ $past(f)) & ~$past(hwdata[15:2])) == 0)
    else $error("zero moved a flag");
  one_clears_a: assert property (wc_r |=> (f & $past(hwdata[15:2])) == 0)
    else $error("one left a flag");
  read_state_a: assert property (rd_r |-> hrdata[15:2] == f)
    else $error("read differs");
  timer_map_a: assert property (rd_r |-> hrdata[15:8] == timer_protect_bits)
    else $error("timer map");
  serial_map_a: assert property (rd_r |-> hrdata[7:2] == serial_unit_protect_bits)
    else $error("serial map");
  spare_bits_a: assert property (rd_r |-> (hrdata & 32'hFFF00001) == 32'h00800000)
    else $error("spare bits");
endmodule
bind pwp_protect_clear pwp_checker chk (.*);
`default_nettype wire

// ==== sim/pwp_protect_clear_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwp_protect_clear_test;
  logic        clk = 0, rst_n = 0, hsel = 1, hwrite = 0, hreadyout, hresp;
  logic        event_router_protect_bit, touch_unit_protect_bit;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, analog_protect_bits;
  logic [5:0]  serial_unit_protect_bits;
  logic [7:0]  timer_protect_bits;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  wire         hready = hreadyout;
  wire [31:0]  pins = {13'h0, touch_unit_protect_bit, analog_protect_bits, timer_protect_bits,
                       serial_unit_protect_bits, event_router_protect_bit};
  int          n_fail = 0, compares = 0;
  pwp_protect_clear dut (.*);
  // Free-running clock.
  initial forever #5 clk = ~clk;
  task check(input logic [31:0] s, e);
    compares++;
    if (s !== e) $display("unexpected %0t %h %h", $time, s, e);
    n_fail += (s !== e);
  endtask
  // Waits for a ready edge, bounded.
  task wt;
    int i;
    for (i = 0; i < 20 && !(hreadyout === 1'b1 && i > 0); i++) @(posedge clk);
    if (i == 20) end_of_test(1);
  endtask
  // One word transfer; read data lands in r.
  task bus(input logic w, input logic [31:0] a, d);
    htrans <= 2'h2; haddr <= a; hwrite <= w;
    wt;
    htrans <= 2'h0; hwdata <= d;
    wt;
    r = hrdata;
  endtask
  task t_reset;
    bus(0, 32'h0, 32'h0);
    check(r, 32'h00800000);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    bus(0, 32'h10, 32'h0);
    check(r, 32'h0);
  endtask
  task t_map;
    bus(1, 32'h4, 32'hFFFFFFFF);
    bus(0, 32'h0, 32'h0);
    check(r, 32'h008FFFFE);
    bus(1, 32'h0, 32'h0000AA04);
    bus(0, 32'h0, 32'h0);
    check(r, 32'h008F55FA);
    check(pins, 32'h0007AAFD);
  endtask
  task t_keep;
    bus(1, 32'h0, 32'h0);
    bus(1, 32'h0, 32'hFFF00001);
    bus(0, 32'h0, 32'h0);
    check(r, 32'h008F55FA);
    bus(1, 32'h0, 32'hFFFFFFFF);
    #1;
    check(pins, 32'h0);
  endtask
  task end_of_test(input int f);
    n_fail += f;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset, then the scenarios.
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_reset;
    t_map;
    t_keep;
    end_of_test(0);
  end
endmodule
`default_nettype wire
